// ### hw/bea_top.sv
// Boot memory glue: maps a byte-wide memory on the low byte lane, times its
// reads with wait states and holds off the next cycle until outputs float.
// Assumes the processor holds its request until ready and one 200 MHz clock.
//
// Notes on behaviour
// - Byte-select bit for data reads is address bit 21.
// - Every eight bytes the index wraps and low address advances by one.
// - Data window starts at FE000000; code offset zero fetches at FFE00000.
// - Code also runs at aliases FFC00000 down to FF000000 in 200000 steps.
// - Without mux, byte enables drive memory low address; data on low lane.
// - Outside byte-boot only six byte-enable codes exist; 1 and 2 unreachable.
// - Memory output enable is driven by the I/O read strobe.
// - 200ns access at 33 MHz needs two wait states before ready.
// - 85ns output-enable time needs three wait states per read.
// - Recovery timer blocks the next cycle until outputs float, 60ns.
// - Address bit 24 high means code fetch, data mux B, cacheable.
// - Low address mux picks byte enables or address bits by alias bit.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
module bea_top
  import bea_pkg::*;
#(
  parameter int RECOVERY_CYCLES = bea_pkg::FLOAT_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_req,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [2:0]  byte_enable_lines,
  input  wire logic [7:0]  mem_data,
  output logic      [7:0]  cpu_data,
  output logic             cpu_ready,
  output logic             cacheable_indicate,
  output logic             data_mux_b,
  output logic             io_read_strobe_n,
  output logic      [2:0]  mem_low_addr,
  output logic             byte_boot_mode,
  output logic             cycle_blocked
);
  import bea_pkg::*;

  initial begin
    if (RECOVERY_CYCLES < FLOAT_CYCLES) $error("recovery shorter than float time");
  end

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // The processor bus is treated as an outside pin group, so each request
  // passes two flops; the address and enables are stable by then.
  logic        req_s1_q, req_s2_q;
  logic [31:0] addr_s1_q, addr_s2_q;
  logic [2:0]  be_s1_q, be_s2_q;
  logic [7:0]  dat_s1_q, dat_s2_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      addr_s1_q <= 32'h0000_0000;
      addr_s2_q <= 32'h0000_0000;
      be_s1_q   <= 3'h0;
      be_s2_q   <= 3'h0;
      dat_s1_q  <= 8'h00;
      dat_s2_q  <= 8'h00;
    end else begin
      req_s1_q  <= cpu_req;
      req_s2_q  <= req_s1_q;
      addr_s1_q <= cpu_addr;
      addr_s2_q <= addr_s1_q;
      be_s1_q   <= byte_enable_lines;
      be_s2_q   <= be_s1_q;
      dat_s1_q  <= mem_data;
      dat_s2_q  <= dat_s1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [1:0] ctrl_q, ctrl_d;
  logic [7:0] acc_wait_q, acc_wait_d;
  logic [7:0] oe_wait_q, oe_wait_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [7:0]  reads_q;
  logic        bad_be_q;

  // One wait cycle in the access phase: pready rises on the second edge.
  always_comb begin
    ctrl_d     = ctrl_q;
    acc_wait_d = acc_wait_q;
    oe_wait_d  = oe_wait_q;
    prdata_d   = prdata_q;
    pready_d   = 1'b0;
    pslverr_d  = 1'b0;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      if (paddr[7:0] == REG_CTRL && paddr[31:8] == '0) begin
        if (pwrite) ctrl_d = pwdata[1:0];
        prdata_d = {30'h0, ctrl_q};
      end else if (paddr[7:0] == REG_ACC_WAIT && paddr[31:8] == '0) begin
        if (pwrite) acc_wait_d = pwdata[7:0];
        prdata_d = {24'h0, acc_wait_q};
      end else if (paddr[7:0] == REG_OE_WAIT && paddr[31:8] == '0) begin
        if (pwrite) oe_wait_d = pwdata[7:0];
        prdata_d = {24'h0, oe_wait_q};
      end else if (paddr[7:0] == REG_STATUS && paddr[31:8] == '0) begin
        prdata_d = {21'h0, bad_be_q, reads_q, cycle_blocked, !io_read_strobe_n};
      end else begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= CTRL_RESET;
      acc_wait_q <= ACC_WAIT_RESET;
      oe_wait_q  <= OE_WAIT_RESET;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      acc_wait_q <= acc_wait_d;
      oe_wait_q  <= oe_wait_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------------
  // Address mapping
  // ---------------------------------------------------------------------------
  logic       hit, code_fetch, low_valid;
  logic [2:0] low_addr, byte_index;

  bea_addr_map u_map (
    .cpu_addr          (addr_s2_q),
    .byte_enable_lines (be_s2_q),
    .alias_sel         (ctrl_q[CTRL_ALIAS]),
    .hit               (hit),
    .code_fetch        (code_fetch),
    .low_addr          (low_addr),
    .low_valid         (low_valid),
    .byte_index        (byte_index)
  );

  // ---------------------------------------------------------------------------
  // Read cycle sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_READY, ST_DONE} bea_state_t;
  bea_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic       strobe_q, strobe_d;
  logic       rdy_q, rdy_d;
  logic       ken_q, ken_d;
  logic       muxb_q, muxb_d;
  logic [2:0] low_q, low_d;
  logic [7:0] dout_q, dout_d;
  logic       rec_start, busy;

  // The longer of the two wait figures governs, since both must be met.
  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    strobe_d  = strobe_q;
    rdy_d     = 1'b0;
    ken_d     = ken_q;
    muxb_d    = muxb_q;
    low_d     = low_q;
    dout_d    = dout_q;
    rec_start = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (req_s2_q && hit && !busy) begin
          st_d     = ST_WAIT;
          strobe_d = 1'b1;
          cnt_d    = max8(acc_wait_q, oe_wait_q);
          ken_d    = code_fetch;
          muxb_d   = code_fetch;
          low_d    = low_addr;
        end
      end
      ST_WAIT: begin
        if (cnt_q == 8'h00) begin
          st_d   = ST_READY;
          rdy_d  = 1'b1;
          dout_d = dat_s2_q;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_READY: begin
        st_d      = ST_DONE;
        strobe_d  = 1'b0;
        rec_start = 1'b1;
      end
      default: begin
        if (!req_s2_q) begin
          st_d  = ST_IDLE;
          ken_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 8'h00;
      strobe_q <= 1'b0;
      rdy_q    <= 1'b0;
      ken_q    <= 1'b0;
      muxb_q   <= 1'b0;
      low_q    <= 3'h0;
      dout_q   <= 8'h00;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      strobe_q <= strobe_d;
      rdy_q    <= rdy_d;
      ken_q    <= ken_d;
      muxb_q   <= muxb_d;
      low_q    <= low_d;
      dout_q   <= dout_d;
    end
  end

  // Status: a count of completed reads and a sticky flag for a read at an unreachable low code.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reads_q  <= 8'h00;
      bad_be_q <= 1'b0;
    end else begin
      if (rec_start) reads_q <= reads_q + 8'h01;
      if (st_q == ST_IDLE && st_d == ST_WAIT && !low_valid) bad_be_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Recovery timer
  // ---------------------------------------------------------------------------
  logic busy_q;

  bea_recovery_timer #(.CYCLES(RECOVERY_CYCLES)) u_rec (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (rec_start),
    .busy  (busy)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy || rec_start;
    end
  end

  assign cpu_data           = dout_q;
  assign cpu_ready          = rdy_q;
  assign cacheable_indicate = ken_q;
  assign data_mux_b         = muxb_q;
  assign io_read_strobe_n   = !strobe_q;
  assign mem_low_addr       = low_q;
  assign byte_boot_mode     = ctrl_q[CTRL_BOOT8];
  assign cycle_blocked      = busy_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_start;
    st_q == ST_IDLE && st_d == ST_WAIT;
  endsequence

  a_ready_one_clk: assert property (@(posedge mclk) disable iff (!rst_n)
    cpu_ready |=> !cpu_ready && io_read_strobe_n) else $error("ready not single");
  a_ready_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
    cpu_ready |-> !io_read_strobe_n) else $error("ready without strobe");
  a_wait_default: assert property (@(posedge mclk) disable iff (!rst_n)
    s_start and (acc_wait_q <= 8'h03 && oe_wait_q == 8'h03) |=> !cpu_ready [*4] ##1 cpu_ready)
    else $error("wait count wrong");
  a_wait_access: assert property (@(posedge mclk) disable iff (!rst_n)
    s_start and (acc_wait_q == 8'h02 && oe_wait_q <= 8'h02) |=> !cpu_ready [*3] ##1 cpu_ready)
    else $error("access wait wrong");
  a_no_start_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    busy |-> st_d != ST_WAIT || st_q != ST_IDLE) else $error("cycle during recovery");
  a_ken_code: assert property (@(posedge mclk) disable iff (!rst_n)
    s_start |=> cacheable_indicate == $past(code_fetch) && data_mux_b == $past(code_fetch))
    else $error("cache enable wrong");
  a_low_mux: assert property (@(posedge mclk) disable iff (!rst_n)
    s_start and ctrl_q[CTRL_ALIAS] |=> mem_low_addr == $past(be_s2_q))
    else $error("low address not from enables");
  a_low_addr: assert property (@(posedge mclk) disable iff (!rst_n)
    s_start and !ctrl_q[CTRL_ALIAS] |=> mem_low_addr == $past(addr_s2_q[5:3]))
    else $error("low address not from address");
  a_data_lane: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(cpu_ready) |-> cpu_data == $past(dat_s2_q)) else $error("data lane wrong");

endmodule // bea_top

// ### hw/bea_pkg.sv
// Package for the byte-wide boot memory access glue.
// Assumes a single 200 MHz clock domain; holds map, field and timing constants.
package bea_pkg;

  // ---------------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------------
  localparam logic [31:0] DATA_WINDOW_BASE = 32'hFE00_0000;
  localparam logic [31:0] CODE_BASE        = 32'hFFE0_0000;
  localparam logic [31:0] ALIAS_LOW_BASE   = 32'hFF00_0000;
  localparam logic [31:0] ALIAS_STEP       = 32'h0020_0000;
  localparam logic [6:0]  TOP_REGION       = 7'h7F;
  localparam int          REGION_LSB       = 25;
  localparam int          BYTE_SEL_BIT     = 21;
  localparam int          CODE_SEL_BIT     = 24;
  localparam logic [2:0]  BYTE_IDX_W       = 3'h3;
  localparam logic [2:0]  UNREACH_LOC_1    = 3'h1;
  localparam logic [2:0]  UNREACH_LOC_2    = 3'h2;
  localparam logic [2:0]  COPY_IMG_SECOND  = 3'h3;

  // ---------------------------------------------------------------------------
  // APB register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_ACC_WAIT  = 8'h04;
  localparam logic [7:0] REG_OE_WAIT   = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0C;
  localparam int         CTRL_ALIAS    = 0;
  localparam int         CTRL_BOOT8    = 1;
  localparam logic [1:0] CTRL_RESET    = 2'h3;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int FLOAT_TIME_PS   = 60000;
  localparam int FLOAT_CYCLES    = (FLOAT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] ACC_WAIT_RESET = 8'h02;
  localparam logic [7:0] OE_WAIT_RESET  = 8'h03;

endpackage

// ### hw/bea_recovery_timer.sv
// Cycle recovery timer: holds off the next bus cycle after a read strobe.
// Assumes start is a one-cycle pulse on mclk when the strobe releases.
`timescale 1ns/100ps
module bea_recovery_timer #(
  parameter int CYCLES = 12
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy
);
  import bea_pkg::*;

  localparam int W = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("recovery count must be at least one");
  end

  logic [W-1:0] cnt_q, cnt_d;

  // Reload on start, then count down; busy while non-zero.
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);

  a_recovery_len: assert property (@(posedge mclk) disable iff (!rst_n)
    start |=> busy [*8]) else $error("recovery window ended early");

endmodule // bea_recovery_timer

// ### hw/bea_addr_map.sv
// Address mapping for the boot memory: decodes the window and forms low bits.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
module bea_addr_map (
  input  wire logic [31:0] cpu_addr,
  input  wire logic [2:0]  byte_enable_lines,
  input  wire logic        alias_sel,
  output logic             hit,
  output logic             code_fetch,
  output logic [2:0]       low_addr,
  output logic             low_valid,
  output logic [2:0]       byte_index
);
  import bea_pkg::*;

  // Byte-enable codes that the bus can form outside byte-boot mode.
  function automatic logic be_reachable(input logic [2:0] be);
    return (be != UNREACH_LOC_1) && (be != UNREACH_LOC_2);
  endfunction

  // Top 32 Mbyte region; bit 24 splits code fetches from data reads.
  always_comb begin
    hit        = (cpu_addr[31:REGION_LSB] == TOP_REGION);
    code_fetch = cpu_addr[CODE_SEL_BIT];
    byte_index = cpu_addr[BYTE_SEL_BIT +: 3];
    if (alias_sel) begin
      low_addr  = byte_enable_lines;
      low_valid = be_reachable(byte_enable_lines);
    end else begin
      low_addr  = cpu_addr[5:3];
      low_valid = 1'b1;
    end
  end

endmodule // bea_addr_map

// ### bench/bea_mem_model.sv
// Byte-wide boot memory model sitting on the low data lane of the glue.
// Assumes the glue's read strobe is its output enable and mclk is the 200 MHz clock.
`timescale 1ns/100ps
module bea_mem_model (
  input  wire logic        mclk,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [2:0]  mem_low_addr,
  input  wire logic        io_read_strobe_n,
  output logic      [7:0]  mem_data
);
  import bea_pkg::*;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [7:0] pattern;
  int         float_q = 0;

  // Each byte is a plain function of its location, so copy images such as the
  // one placed at locations 0 and 3 read like any other byte.
  assign pattern = {cpu_addr[23:21], 2'h0, mem_low_addr} ^ 8'hA5;

  // The outputs keep driving for the float time after the enable rises, which
  // is the window that the recovery timer has to cover.
  always @(posedge mclk) begin
    if (!io_read_strobe_n) begin
      float_q <= FLOAT_CYCLES;
    end else if (float_q > 0) begin
      float_q <= float_q - 1;
    end
  end

  // The memory answers without a clock; once floated the lane shows the inverse
  // pattern, so a stale byte cannot pass by luck.
  always_comb begin
    if (!io_read_strobe_n || float_q != 0) begin
      mem_data = pattern;
    end else begin
      mem_data = ~pattern;
    end
  end
endmodule // bea_mem_model

// ### bench/tb_bea_top.sv
// Self-checking bench for the boot memory glue: APB set-up plus processor reads.
// Assumes the glue and a behavioural memory model on one 200 MHz clock.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb_bea_top;
  import bea_pkg::*;
  localparam int RC = 12;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic        pready, pslverr, cpu_req = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic [2:0]  byte_enable_lines = 3'h0, mem_low_addr;
  logic [7:0]  mem_data, cpu_data;
  logic        cpu_ready, cacheable_indicate, data_mux_b, io_read_strobe_n, byte_boot_mode, cycle_blocked;
  logic [31:0] rd;
  logic        err;
  int          fails = 0, total_checks = 0, cyc = 0, tr = -100;
  logic [31:0] dw [6] = '{32'hFE00_0000, 32'hFE20_0000, 32'hFE60_0000, 32'hFEE0_0000, 32'hFE00_0008, 32'hFE20_0008};
  logic [31:0] cw [3] = '{32'hFFE0_0000, 32'hFFC0_0000, 32'hFF00_0000};

  // Clock and a free cycle count used to measure gaps between reads.
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  bea_top #(.RECOVERY_CYCLES(RC)) i_bea_top (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .byte_enable_lines(byte_enable_lines), .mem_data(mem_data),
    .cpu_data(cpu_data), .cpu_ready(cpu_ready), .cacheable_indicate(cacheable_indicate),
    .data_mux_b(data_mux_b), .io_read_strobe_n(io_read_strobe_n), .mem_low_addr(mem_low_addr),
    .byte_boot_mode(byte_boot_mode), .cycle_blocked(cycle_blocked));
  bea_mem_model i_bea_mem_model (.mclk(mclk), .cpu_addr(cpu_addr), .mem_low_addr(mem_low_addr),
    .io_read_strobe_n(io_read_strobe_n), .mem_data(mem_data));

  // ---------------------------------------------------------------------------
  // Bus tasks; each starts just after an edge; apb ends one edge and cpu_rd two edges after release
  // ---------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // One processor read: checks lane address, cache hint, latency and data.
  task automatic cpu_rd(input logic [31:0] a, input logic [2:0] be, input logic [2:0] lo, input int nw);
    int n;
    n = 0;
    cpu_addr <= a;
    byte_enable_lines <= be;
    cpu_req <= 1'b1;
    while (io_read_strobe_n !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    `CHK("recovery gap", 1'b1, (cyc - tr >= RC))
    `CHK("low address", lo, mem_low_addr)
    `CHK("cache hint", a[24], cacheable_indicate)
    `CHK("data mux", a[24], data_mux_b)
    n = 0;
    while (cpu_ready !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    `CHK("ready latency", nw + 1, n)
    `CHK("strobe at ready", 1'b0, io_read_strobe_n)
    `CHK("read byte", {a[23:21], 2'h0, lo} ^ 8'hA5, cpu_data)
    cpu_req <= 1'b0;
    @(posedge mclk);
    tr = cyc;
    `CHK("strobe release", 1'b1, io_read_strobe_n)
    @(posedge mclk);
    `CHK("recovery active", 1'b1, cycle_blocked)
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog of 8000 cycles, well above the few hundred cycles the sequence needs.
  initial begin
    #40000;
    fails++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    `CHK("strobe idle in reset", 1'b1, io_read_strobe_n)
    rst_n <= 1'b1;
    @(posedge mclk);
    `CHK("byte boot after reset", 1'b1, byte_boot_mode)
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 32'(i * 4), 32'h0);
      `CHK("reg reset", (i == 0) ? 32'h3 : (i == 1) ? 32'h2 : (i == 2) ? 32'h3 : 32'h0, rd)
    end
    apb(1'b0, 32'h10, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    // Alias mode: the byte enables become the low memory address, all eight codes.
    for (int b = 0; b < 8; b++) cpu_rd(32'hFE00_0000, 3'(b), 3'(b), 3);
    apb(1'b0, 32'(REG_STATUS), 32'h0);
    `CHK("unreachable code seen", 1'b1, rd[10])
    `CHK("read count", 8'h08, rd[9:2])
    // Mux on address: the byte enables must be ignored.
    apb(1'b1, 32'(REG_CTRL), 32'h0);
    `CHK("byte boot cleared", 1'b0, byte_boot_mode)
    foreach (dw[i]) cpu_rd(dw[i], 3'h7, dw[i][5:3], 3);
    foreach (cw[i]) cpu_rd(cw[i], 3'h5, cw[i][5:3], 3);
    // Longer and shorter wait settings, applied as the larger of the two.
    apb(1'b1, 32'(REG_ACC_WAIT), 32'h6);
    apb(1'b0, 32'(REG_ACC_WAIT), 32'h0);
    `CHK("access wait write", 32'h6, rd)
    cpu_rd(32'hFE40_0010, 3'h0, 3'h2, 6);
    apb(1'b1, 32'(REG_ACC_WAIT), 32'h2);
    apb(1'b1, 32'(REG_OE_WAIT), 32'h2);
    cpu_rd(32'hFE00_0038, 3'h0, 3'h7, 2);
    // Just below the window nothing may start.
    cpu_addr <= 32'hFDFF_FFF8;
    cpu_req <= 1'b1;
    repeat (30) begin
      @(posedge mclk);
      `CHK("no strobe outside window", 1'b1, io_read_strobe_n)
    end
    cpu_req <= 1'b0;
    repeat (3) @(posedge mclk);
    complete_run();
  end
endmodule // tb_bea_top
